/* File: apdu_pkg.sv */
// apdu_pkg: constants and carrier types for the automatic power-down unit
// assumes a single 25 MHz system clock domain; pins arrive asynchronous
package apdu_pkg;
    localparam int APDU_CNT_W = 4;
    localparam logic [3:0] APDU_IDLE_LIMIT = 4'hf;
    localparam int APDU_BIT_AUTO = 1;
    localparam int APDU_BIT_SLOW = 3;
    localparam int APDU_BIT_ARRCLK = 4;
    localparam int APDU_BIT_MCLK = 5;
    localparam int APDU_BIT_CNTL0 = 2;
    localparam logic [7:0] APDU_REG_RESET = 8'h00;

    typedef enum logic {APDU_RUN, APDU_SLEEP} apdu_state_t;

    // memory selects and the io window
    typedef struct packed {
        logic flash;
        logic second;
        logic sram;
        logic iowin;
    } apdu_sel_t;

    // pin output-enable groups by port function
    typedef struct packed {
        logic mcu_io;
        logic pld_out;
        logic addr_out;
        logic data_port;
        logic periph;
    } apdu_pins_t;
endpackage : apdu_pkg

/* File: apdu_top.sv */
// apdu_top: strobe-idle counter, power-down flag and the gating it drives
// assumes strobe, clock input, chip select and reset pins are asynchronous
`timescale 1ns/1ns
module apdu_top (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rstn,
    input wire logic i_por_n,
    // pins
    input wire logic i_host_addr_strobe,
    input wire logic i_common_clock_input,
    input wire logic i_chip_sel_n,
    input wire logic i_reset_pin,
    // control register writes from the host
    input wire logic i_ctrl0_we,
    input wire logic i_ctrl2_we,
    input wire logic [7:0] i_wdata,
    // memory requests and array activity
    input wire apdu_pkg::apdu_sel_t i_mem_req,
    input wire logic i_array_in_toggle,
    input wire apdu_pkg::apdu_pins_t i_pin_oe,
    // outputs
    output logic o_power_down_flag,
    output logic [7:0] o_power_ctrl_reg0,
    output logic [7:0] o_power_ctrl_reg2,
    output apdu_pkg::apdu_sel_t o_mem_sel,
    output logic o_bus_to_arrays,
    output logic o_array_clk_en,
    output logic o_mcell_clk_en,
    output logic o_array_standby,
    output apdu_pkg::apdu_pins_t o_pin_oe
);
    import apdu_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // synchronisers; first stage feeds only the second
    logic [3:0] s1_r;
    logic [3:0] s2_r;
    logic [3:0] s3_r;
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            s1_r <= 4'h0;
            s2_r <= 4'h0;
            s3_r <= 4'h0;
        end else begin
            s1_r <= {i_host_addr_strobe, i_common_clock_input,
                     i_chip_sel_n, i_reset_pin};
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    wire strobe_edge = s2_r[3] & ~s3_r[3];
    // counter always sees the clock input, whatever the blocking bits
    wire cki_edge = s2_r[2] & ~s3_r[2];
    wire csn_fall = ~s2_r[1] & s3_r[1];
    wire rst_rise = s2_r[0] & ~s3_r[0];

    ////////////////////////////////////////////////////////////////////
    // power control registers: power-on reset only
    logic [7:0] ctrl0_r;
    logic [7:0] ctrl2_r;
    always_ff @(posedge i_clk_sys or negedge i_por_n) begin
        if (!i_por_n) begin
            ctrl0_r <= APDU_REG_RESET;
            ctrl2_r <= APDU_REG_RESET;
        end else begin
            if (i_ctrl0_we) begin
                ctrl0_r <= i_wdata;
            end
            if (i_ctrl2_we) begin
                ctrl2_r <= i_wdata;
            end
        end
    end

    wire auto_en = ctrl0_r[APDU_BIT_AUTO];
    wire slow = ctrl0_r[APDU_BIT_SLOW];
    wire arrclk_off = ctrl0_r[APDU_BIT_ARRCLK];
    wire mclk_off = ctrl0_r[APDU_BIT_MCLK];
    wire cntl0_off = ctrl2_r[APDU_BIT_CNTL0];

    ////////////////////////////////////////////////////////////////////
    // idle counter and state
    logic [APDU_CNT_W-1:0] cnt_r;
    logic [APDU_CNT_W-1:0] cnt_nxt;
    apdu_state_t st_r;
    apdu_state_t st_nxt;
    wire wake = strobe_edge | csn_fall | rst_rise;
    wire at_limit = (cnt_r == APDU_IDLE_LIMIT);

    always_comb begin
        cnt_nxt = cnt_r;
        st_nxt = st_r;
        case (st_r)
            APDU_RUN: begin
                if (!auto_en || strobe_edge) begin
                    cnt_nxt = '0;
                end else if (cki_edge) begin
                    cnt_nxt = cnt_r + 4'h1;
                    if (cnt_r == APDU_IDLE_LIMIT - 4'h1) begin
                        st_nxt = APDU_SLEEP;
                    end
                end
            end
            APDU_SLEEP: begin
                if (wake || !auto_en) begin
                    st_nxt = APDU_RUN;
                    cnt_nxt = '0;
                end
                // counter holds at terminal count
            end
            default: begin
                st_nxt = APDU_RUN;
                cnt_nxt = '0;
            end
        endcase
    end

    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            cnt_r <= '0;
            st_r <= APDU_RUN;
        end else begin
            cnt_r <= cnt_nxt;
            st_r <= st_nxt;
        end
    end

    wire pd_nxt = (st_nxt == APDU_SLEEP);
    wire cs_ok = ~s2_r[1];

    ////////////////////////////////////////////////////////////////////
    // gated outputs
    apdu_sel_t sel_nxt;
    apdu_pins_t oe_nxt;
    assign sel_nxt = (pd_nxt || !cs_ok) ? '0 : i_mem_req;
    // io and logic outputs keep their enables; address/data/periph released
    assign oe_nxt = '{mcu_io: i_pin_oe.mcu_io,
                      pld_out: i_pin_oe.pld_out,
                      addr_out: pd_nxt ? 1'b0 : i_pin_oe.addr_out,
                      data_port: pd_nxt ? 1'b0 : i_pin_oe.data_port,
                      periph: pd_nxt ? 1'b0 : i_pin_oe.periph};
    // arrays idle only on full speed off with no live input
    wire live_in = i_array_in_toggle & ~cntl0_off;
    wire standby_nxt = slow & ~live_in;

    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            o_power_down_flag <= 1'b0;
            o_power_ctrl_reg0 <= APDU_REG_RESET;
            o_power_ctrl_reg2 <= APDU_REG_RESET;
            o_mem_sel <= '0;
            o_bus_to_arrays <= 1'b1;
            o_array_clk_en <= 1'b1;
            o_mcell_clk_en <= 1'b1;
            o_array_standby <= 1'b0;
            o_pin_oe <= '0;
        end else begin
            o_power_down_flag <= pd_nxt;
            o_power_ctrl_reg0 <= ctrl0_r;
            o_power_ctrl_reg2 <= ctrl2_r;
            o_mem_sel <= sel_nxt;
            o_bus_to_arrays <= ~pd_nxt;
            o_array_clk_en <= ~arrclk_off;
            o_mcell_clk_en <= ~mclk_off;
            o_array_standby <= standby_nxt;
            o_pin_oe <= oe_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // checks
    // one-cycle events that the idle logic reacts to
    sequence s_strobe;
        strobe_edge;
    endsequence

    sequence s_asleep;
        st_r == APDU_SLEEP && auto_en;
    endsequence

    sequence s_count_step;
        st_r == APDU_RUN && auto_en && !strobe_edge && cki_edge;
    endsequence

    // the fifteenth idle period
    sequence s_last_idle;
        s_count_step ##0 cnt_r == APDU_IDLE_LIMIT - 4'h1;
    endsequence

    sequence s_quiet_sleep;
        s_asleep ##0 !wake;
    endsequence

    sequence s_csn_wake;
        s_asleep ##0 csn_fall;
    endsequence

    sequence s_rst_wake;
        s_asleep ##0 rst_rise;
    endsequence

    // idle counter and power-down entry
    a_strobe_wakes: assert property (
        @(posedge i_clk_sys) disable iff (!i_rstn)
        s_strobe |=> !o_power_down_flag)
        else $error("strobe did not clear power-down");
    a_strobe_clear: assert property (
        @(posedge i_clk_sys) disable iff (!i_rstn)
        s_strobe |=> cnt_r == 4'h0)
        else $error("strobe did not clear the idle counter");
    a_count_step: assert property (
        @(posedge i_clk_sys) disable iff (!i_rstn)
        s_count_step |=> cnt_r == $past(cnt_r) + 4'h1)
        else $error("idle counter missed a clock input period");
    a_clk_kept: assert property (
        @(posedge i_clk_sys) disable iff (!i_rstn)
        s_count_step ##0 (arrclk_off || mclk_off) |=> cnt_r != $past(cnt_r))
        else $error("blocking bits stopped the idle counter");
    a_sleep_entry: assert property (
        @(posedge i_clk_sys) disable iff (!i_rstn)
        s_last_idle |=> o_power_down_flag)
        else $error("fifteenth idle period did not enter power-down");
    a_entry_count: assert property (
        @(posedge i_clk_sys) disable iff (!i_rstn)
        $rose(o_power_down_flag) |-> at_limit)
        else $error("power-down entered without fifteen idle periods");
    a_need_enable: assert property (
        @(posedge i_clk_sys) disable iff (!i_rstn)
        !auto_en |=> cnt_r == 4'h0)
        else $error("counter ran while disabled");
    a_count_hold: assert property (
        @(posedge i_clk_sys) disable iff (!i_rstn)
        s_quiet_sleep ##0 at_limit |=> at_limit)
        else $error("counter moved at terminal count");

    // staying asleep and the wake paths
    a_sleep_hold: assert property (
        @(posedge i_clk_sys) disable iff (!i_rstn)
        s_quiet_sleep |=> o_power_down_flag)
        else $error("power-down left without a wake event");
    a_csn_wake: assert property (
        @(posedge i_clk_sys) disable iff (!i_rstn)
        s_csn_wake |=> !o_power_down_flag)
        else $error("chip select low did not wake");
    a_rst_wake: assert property (
        @(posedge i_clk_sys) disable iff (!i_rstn)
        s_rst_wake |=> !o_power_down_flag)
        else $error("reset pin rise did not wake");

    // gating while in power-down or deselected
    a_mem_desel: assert property (
        @(posedge i_clk_sys) disable iff (!i_rstn)
        o_power_down_flag |-> o_mem_sel == '0)
        else $error("memory selected in power-down");
    a_bus_block: assert property (
        @(posedge i_clk_sys) disable iff (!i_rstn)
        o_power_down_flag |-> !o_bus_to_arrays)
        else $error("bus reached arrays in power-down");
    a_bus_tracks: assert property (
        @(posedge i_clk_sys) disable iff (!i_rstn)
        !o_power_down_flag |-> o_bus_to_arrays)
        else $error("bus blocked outside power-down");
    a_cs_desel: assert property (
        @(posedge i_clk_sys) disable iff (!i_rstn)
        $past(s2_r[1]) |-> o_mem_sel == '0)
        else $error("memory selected with chip select high");
    a_cs_pass: assert property (
        @(posedge i_clk_sys) disable iff (!i_rstn)
        !pd_nxt && cs_ok |=> o_mem_sel == $past(i_mem_req))
        else $error("memory request lost while selected");
    a_data_tris: assert property (
        @(posedge i_clk_sys) disable iff (!i_rstn)
        o_power_down_flag |-> !o_pin_oe.data_port && !o_pin_oe.periph)
        else $error("data port driven in power-down");
    a_addr_rel: assert property (
        @(posedge i_clk_sys) disable iff (!i_rstn)
        o_power_down_flag |-> !o_pin_oe.addr_out)
        else $error("address output driven in power-down");
    a_io_kept: assert property (
        @(posedge i_clk_sys) disable iff (!i_rstn)
        o_power_down_flag |-> o_pin_oe.mcu_io == $past(i_pin_oe.mcu_io) &&
            o_pin_oe.pld_out == $past(i_pin_oe.pld_out))
        else $error("io or logic pin enable changed by power-down");

    // array power, clock gating and register copies
    a_fast_awake: assert property (
        @(posedge i_clk_sys) disable iff (!i_rstn)
        !slow |=> !o_array_standby)
        else $error("arrays idle in full-speed mode");
    a_idle_stby: assert property (
        @(posedge i_clk_sys) disable iff (!i_rstn)
        slow && !live_in |=> o_array_standby)
        else $error("quiet arrays kept awake with full speed off");
    a_live_awake: assert property (
        @(posedge i_clk_sys) disable iff (!i_rstn)
        slow && live_in |=> !o_array_standby)
        else $error("arrays idle with a live input");
    a_clk_bits: assert property (
        @(posedge i_clk_sys) disable iff (!i_rstn)
        $past(i_rstn) |-> o_array_clk_en == !$past(arrclk_off) &&
            o_mcell_clk_en == !$past(mclk_off))
        else $error("clock enable does not follow its blocking bit");
    a_ctrl_copy: assert property (
        @(posedge i_clk_sys) disable iff (!i_rstn)
        $past(i_rstn) |-> o_power_ctrl_reg0 == $past(ctrl0_r) &&
            o_power_ctrl_reg2 == $past(ctrl2_r))
        else $error("control register copy is stale");
endmodule : apdu_top

/* File: apdu_host_model.sv */
// apdu_host_model: host strobe and a free-running clock input
// assumes the bench raises i_active just after a system clock edge
`timescale 1ns/1ns
module apdu_host_model (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rstn,
    // control
    input wire logic i_active,
    // pins
    output logic o_strobe,
    output logic o_common_clock_input
);
    logic [2:0] ph_r;
    always @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) ph_r <= 3'h0;
        else ph_r <= ph_r + 3'h1;
    end
    // clock input at sys/8; strobe rises two cycles after it
    assign o_common_clock_input = ph_r < 3'h4;
    assign o_strobe = i_active && ph_r[2:1] == 2'h1;
endmodule : apdu_host_model

/* File: testbench.sv */
// testbench: idle counting, power-down gating and wake paths
// assumes apdu_top and apdu_host_model compiled before it
`timescale 1ns/1ns
module testbench;
    import apdu_pkg::*;
    logic clk = 0, rstn = 0, por_n = 0, act = 1, csn = 0, rpin = 0;
    logic we0 = 0, we2 = 0, tog = 0, sq, cq, strobe, common_clock_input;
    logic flag, bus, aclk, mclk, stby;
    logic [7:0] wd = 8'h00, r0, r2, m0, m2, v0, v2;
    apdu_sel_t req = '0, msel;
    apdu_pins_t poe = '0, ooe;
    int seed = 92, mismatches = 0, total_checks = 0, idle = 0, n, k;
    always #20 clk = ~clk;
    apdu_host_model host_u (.i_clk_sys(clk), .i_rstn(rstn),
        .i_active(act), .o_strobe(strobe), .o_common_clock_input(common_clock_input));
    apdu_top dut_u (.i_clk_sys(clk), .i_rstn(rstn), .i_por_n(por_n),
        .i_host_addr_strobe(strobe), .i_common_clock_input(common_clock_input),
        .i_chip_sel_n(csn), .i_reset_pin(rpin), .i_ctrl0_we(we0),
        .i_ctrl2_we(we2), .i_wdata(wd), .i_mem_req(req),
        .i_array_in_toggle(tog), .i_pin_oe(poe),
        .o_power_down_flag(flag), .o_power_ctrl_reg0(r0),
        .o_power_ctrl_reg2(r2), .o_mem_sel(msel), .o_bus_to_arrays(bus),
        .o_array_clk_en(aclk), .o_mcell_clk_en(mclk),
        .o_array_standby(stby), .o_pin_oe(ooe));
    // clock-input rises since the last strobe rise
    always @(posedge clk) begin
        if (strobe && !sq) idle = 0;
        else if (common_clock_input && !cq) idle++;
        sq = strobe;
        cq = common_clock_input;
    end
    ////////////////////////////////////////////////////////////////////
    task automatic close_out;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : close_out
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        total_checks++;
        if (g !== e) begin
            mismatches++;
            $display("Error t=%0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    task automatic cyc(input int c);
        repeat (c) @(posedge clk);
        #1;
    endtask : cyc
    task automatic wflag(input logic v, input int b);
        n = 0;
        while (flag !== v && n < b) begin
            cyc(1);
            n++;
        end
        if (n >= b) begin
            $display("Error t=%0t got %h exp %h", $time, flag, v);
            mismatches++;
            close_out();
        end
    endtask : wflag
    task automatic wr(input logic s, input logic [7:0] v);
        wd = v;
        if (s) m2 = v;
        else m0 = v;
        we2 = s;
        we0 = !s;
        cyc(1);
        we0 = 0;
        we2 = 0;
        cyc(3);
    endtask : wr
    task automatic chk_out(input logic sl);
        chk(flag, sl);
        chk(bus, !sl);
        chk(msel, (sl || csn) ? 4'h0 : req);
        chk(ooe, sl ? (poe & 5'h18) : poe);
        chk(aclk, !m0[4]);
        chk(mclk, !m0[5]);
        chk(stby, m0[3] && !(tog && !m2[2]));
    endtask : chk_out
    ////////////////////////////////////////////////////////////////////
    initial begin
        m0 = 8'h00;
        m2 = 8'h00;
        cyc(20);
        rstn = 1;
        por_n = 1;
        cyc(6);
        chk_out(0);
        chk(r0, 8'h00);
        chk(r2, 8'h00);
        $display("test reset done");
        wr(0, 8'h08);
        act = 0;
        cyc(200);
        chk_out(0);
        $display("test auto off done");
        for (k = 0; k < 3; k++) begin
            {req, poe, tog} = 10'($random(seed)) | 10'(k < 2);
            act = 1;
            v0 = (8'($random(seed)) & 8'h38) | 8'h02;
            v2 = 8'($random(seed)) & 8'h04;
            if (k == 0) begin
                v0 = v0 | 8'h38;
                v2 = 8'h04;
            end
            if (k == 1) begin
                v0 = v0 | 8'h08;
                v2 = 8'h00;
            end
            wr(0, v0);
            wr(1, v2);
            chk(r0, m0);
            chk(r2, m2);
            csn = k == 1;
            cyc(6);
            chk_out(0);
            act = 0;
            wflag(1, 200);
            chk(idle, 15);
            cyc(20);
            chk_out(1);
            if (k == 0) act = 1;
            if (k == 1) csn = 0;
            if (k == 2) rpin = 1;
            wflag(0, 20);
            rpin = 0;
            act = 1;
            cyc(8);
            chk_out(0);
            $display("test sleep %0d done", k);
        end
        rstn = 0;
        cyc(2);
        rstn = 1;
        cyc(6);
        chk(r0, m0);
        chk(flag, 0);
        $display("test second reset done");
        close_out();
    end
endmodule : testbench
